// [inc/pwc_cfg.svh]
// Register offsets, field positions and reset values of the channel timer core.
// Assumes inclusion by bare name from the package and the core module.
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH

// Number of channels and pairs
`define PWC_NCH 6
`define PWC_NPAIR 3

// Byte offsets of the register map
`define PWC_OFS_ENABLE 8'h00
`define PWC_OFS_POLARITY 8'h04
`define PWC_OFS_ALIGN 8'h08
`define PWC_OFS_PAIRING 8'h0c
`define PWC_OFS_STATUS 8'h0c
`define PWC_OFS_STATE 8'h70
`define PWC_BASE_COUNT 8'h10
`define PWC_BASE_PERIOD 8'h30
`define PWC_BASE_DUTY 8'h50
`define PWC_REGION_SPAN 8'h18

// Pairing field positions
`define PWC_BIT_JOIN01 0
`define PWC_BIT_JOIN23 1
`define PWC_BIT_JOIN45 2

// Reset values
`define PWC_RST_BITS6 6'h00
`define PWC_RST_BITS3 3'h0
`define PWC_RST_BYTE 8'h00

`endif

// [inc/pwc_pkg.sv]
// Types shared by the channel timer core.
// Assumes pwc_cfg.svh is reachable on the include path.
package pwc_pkg;

    `include "pwc_cfg.svh"

    // Outcome of one counting step of a channel or joined pair
    typedef struct packed {
        logic [15:0] cnt;
        logic dn;
        logic rst;
        logic tog;
        logic load;
    } pwc_step_s;

    // Region hit of a bus address: valid flag and channel index
    typedef struct packed {
        logic hit;
        logic [2:0] idx;
    } pwc_slot_s;

endpackage : pwc_pkg

// [test/pwc_core_monitor.sv]
// Port checker for the channel timer core.
// Assumes a bind onto pwc_core; one clock domain, synchronous active-low reset.
`timescale 1ns/1ps

module pwc_core_monitor (
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Bus handshake
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Channel side
    input wire logic [5:0] chan_tick,
    input wire logic [5:0] pwm_out,
    input wire logic [5:0] pwm_out_en
);
    // Every check runs on the core clock, off during reset
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // Any bus request in flight
    wire logic req = avs_read | avs_write;

    // Bus handshake: one wait state, none when idle, read data held
    a_wait_first: assert property (req && !$past(req) |-> avs_waitrequest)
        else $error("new request answered without a wait state");
    a_one_wait: assert property (req && avs_waitrequest |=> !req || !avs_waitrequest)
        else $error("request kept waiting beyond one cycle");
    a_idle_nowait: assert property (!req |-> !avs_waitrequest)
        else $error("wait asserted while idle");
    a_read_stand: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");

    // Channel outputs
    a_reset_quiet: assert property ($rose(resetn) |-> pwm_out == 6'h00 && pwm_out_en == 6'h00)
        else $error("outputs active straight after reset");
    a_out_gated: assert property ((pwm_out & ~pwm_out_en) == 6'h00)
        else $error("output high on a disabled channel");
    a_enable_cause: assert property ($changed(pwm_out_en) |-> $past(avs_write) || $past(avs_write, 2))
        else $error("output enable moved without a write");
    a_idle_hold: assert property ((chan_tick == 6'h00 && !avs_write) [*3] |=> $stable(pwm_out))
        else $error("output moved with no tick and no write");
endmodule : pwc_core_monitor

// [test/pwc_core_test.sv]
// Self-checking bench for the channel timer core.
// Assumes pwc_pkg compiled first and the checker bound below.
`timescale 1ns/1ps

module pwc_core_test;
    import pwc_pkg::*;

    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [5:0] chan_tick = 6'h00;
    logic [5:0] pwm_out;
    logic [5:0] pwm_out_en;
    int err_total = 0;
    int total_checks = 0;

    // 125 MHz clock
    always #4 core_clk = ~core_clk;

    pwc_core pwc_core_i (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .chan_tick(chan_tick), .pwm_out(pwm_out),
        .pwm_out_en(pwm_out_en));

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // One Avalon cycle; held until waitrequest is sampled low at a falling edge, then released at the next rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        logic ws;
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        for (n = 0; n < 50; n++)
        begin
            @(negedge core_clk);
            ws = avs_waitrequest;
            r = avs_readdata;
            @(posedge core_clk);
            if (ws === 1'b0)
                break;
        end
        if (n == 50)
        begin
            err_total++;
            print_verdict();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask : rd

    // A run of count ticks on the given channels
    task ticks(input logic [5:0] m, input int n);
        repeat (n)
        begin
            @(posedge core_clk);
            chan_tick <= m;
        end
        @(posedge core_clk);
        chan_tick <= 6'h00;
    endtask : ticks

    task t_reset;
        logic [7:0] adr [7];
        adr = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18, 8'h38, 8'h58};
        foreach (adr[i])
            rd(adr[i], 32'h0);
        check({26'h0, pwm_out_en}, 32'h0);
        rd(8'hfc, 32'h0);
        $display("reset test done");
    endtask : t_reset

    // Channel 2 stepped by hand: counting, wrap, double buffer, hold, clear
    task t_step;
        wr(8'h38, 32'h4);
        wr(8'h58, 32'h1);
        wr(8'h18, 32'h0);
        wr(8'h00, 32'h4);
        ticks(6'h04, 5);
        rd(8'h18, 32'h1);
        wr(8'h38, 32'h8);
        ticks(6'h04, 5);
        rd(8'h18, 32'h2);
        ticks(6'h04, 5);
        rd(8'h18, 32'h7);
        wr(8'h00, 32'h0);
        ticks(6'h04, 3);
        rd(8'h18, 32'h7);
        wr(8'h00, 32'h4);
        ticks(6'h04, 2);
        rd(8'h18, 32'h1);
        wr(8'h18, 32'h55);
        rd(8'h18, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h38, 32'h4);
        wr(8'h08, 32'h4);
        wr(8'h18, 32'h0);
        wr(8'h00, 32'h4);
        ticks(6'h04, 6);
        rd(8'h18, 32'h2);
        rd(8'h70, 32'h404);
        ticks(6'h04, 3);
        rd(8'h18, 32'h1);
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h0);
        $display("step test done");
    endtask : t_step

    // Free-running channel 2; counts high cycles and rising edges in 16 clocks
    task wave(input logic ctr, input logic pol, input logic [7:0] per, input logic [7:0] dty,
              input int hi_exp, input int rise_exp);
        int hi;
        int lo;
        int rise;
        logic prev;
        wr(8'h00, 32'h0);
        wr(8'h38, {24'h0, per});
        wr(8'h58, {24'h0, dty});
        wr(8'h04, {29'h0, pol, 2'h0});
        wr(8'h08, {29'h0, ctr, 2'h0});
        wr(8'h18, 32'h0);
        wr(8'h00, 32'h4);
        @(posedge core_clk);
        chan_tick <= 6'h3f;
        repeat (10) @(posedge core_clk);
        hi = 0;
        lo = 0;
        rise = 0;
        @(negedge core_clk);
        prev = pwm_out[2];
        repeat (16)
        begin
            @(negedge core_clk);
            hi += (pwm_out[2] === 1'b1);
            lo += (pwm_out[2] === 1'b0);
            rise += (pwm_out[2] === 1'b1 && prev === 1'b0);
            prev = pwm_out[2];
        end
        check({31'h0, pwm_out_en[2]}, 32'h1);
        check(hi, hi_exp);
        check(lo, 16 - hi_exp);
        check(rise, rise_exp);
        @(posedge core_clk);
        chan_tick <= 6'h00;
        wr(8'h00, 32'h0);
        $display("wave test done");
    endtask : wave

    // Channels 0 and 1 joined into one 16-bit channel
    task t_join;
        wr(8'h0c, 32'h1);
        wr(8'h30, 32'h1);
        wr(8'h34, 32'h0);
        wr(8'h54, 32'h80);
        wr(8'h14, 32'h0);
        wr(8'h00, 32'h2);
        ticks(6'h02, 300);
        rd(8'h14, 32'h2c);
        rd(8'h10, 32'h2c);
        check({26'h0, pwm_out_en}, 32'h2);
        ticks(6'h01, 5);
        rd(8'h14, 32'h2c);
        wr(8'h10, 32'h0);
        rd(8'h14, 32'h0);
        wr(8'h00, 32'h1);
        ticks(6'h03, 5);
        rd(8'h14, 32'h0);
        check({26'h0, pwm_out_en}, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h0c, 32'h0);
        $display("join test done");
    endtask : t_join

    // Main sequence
    initial
    begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_step();
        wave(1'b0, 1'b0, 8'h4, 8'h1, 12, 4);
        wave(1'b0, 1'b1, 8'h4, 8'h1, 4, 4);
        wave(1'b1, 1'b0, 8'h4, 8'h1, 12, 2);
        wave(1'b1, 1'b1, 8'h4, 8'h1, 4, 2);
        wave(1'b0, 1'b1, 8'h4, 8'h0, 0, 0);
        wave(1'b1, 1'b0, 8'h4, 8'h0, 16, 0);
        wave(1'b0, 1'b1, 8'h0, 8'h2, 16, 0);
        wave(1'b0, 1'b0, 8'h0, 8'h2, 0, 0);
        wave(1'b1, 1'b1, 8'h4, 8'h4, 16, 0);
        wave(1'b0, 1'b0, 8'h4, 8'h5, 0, 0);
        t_join();
        print_verdict();
    end
endmodule : pwc_core_test

bind pwc_core pwc_core_monitor pwc_core_monitor_i (.core_clk(core_clk), .resetn(resetn),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .chan_tick(chan_tick), .pwm_out(pwm_out),
    .pwm_out_en(pwm_out_en));

// [verilog/pwc_core.sv]
// Six-channel 8-bit pulse-width channel timer core with optional 16-bit pairing,
// reached over an Avalon-MM slave with waitrequest.
// Assumes chan_tick comes from prescaler logic on core_clk, one pulse per count.
//
// Function
// RULE1 - Counter write clears, counts up, loads buffers
// RULE2 - Enabled counter write restarts period, polarity level
// RULE3 - Enabled counts from last value, disabled holds
// RULE4 - Counter returns zero at effective period end
// RULE5 - Alignment bit picks left or center mode
// RULE6 - Left mode counts up, duty match toggles
// RULE7 - Left period match resets counter, flop, loads
// RULE8 - Left counter runs zero to period minus one
// RULE9 - Center counts up/down, zero forces up
// RULE10 - Center period match turns down, duty toggles
// RULE11 - Center down at zero turns up, loads
// RULE12 - Center effective period is twice period
// RULE13 - Polarity picks duty or period minus duty
// RULE14 - Pair bits join channels, even is high
// RULE15 - Joined clock, pin, polarity from odd channel
// RULE16 - Joined enable from odd; even output off
// RULE17 - Any joined counter byte write clears all
// RULE18 - Joined alignment follows odd channel bit
// RULE19 - Software changes pairing only while disabled
// RULE20 - Duty zero or above period fixes output
// RULE21 - Period zero holds counter, fixes output
// RULE22 - Software selects alignment before enabling
// RULE23 - Software writes counter before enabling
// RULE24 - Period, duty double buffered while enabled
// RULE25 - Reset: count up, disabled, nothing advances
// RULE26 - Joined comparisons use full sixteen bits
`timescale 1ns/1ps

module pwc_core
    import pwc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // Avalon-MM slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Selected prescaled clock ticks, one per channel
    input wire logic [5:0] chan_tick,
    // Channel outputs
    output logic [5:0] pwm_out,
    output logic [5:0] pwm_out_en
);

    `include "pwc_cfg.svh"

    // One counting step of a channel, 16-bit wide so joined pairs share it
    function automatic pwc_step_s pwc_step(
        input logic [15:0] cnt,
        input logic dn,
        input logic [15:0] per,
        input logic [15:0] dty,
        input logic ctr
    );
        pwc_step_s r;
        r.cnt = cnt;
        r.dn = dn;
        r.rst = 1'b0;
        r.tog = 1'b0;
        r.load = 1'b0;
        if (per == 16'h0000)
        begin
            r.cnt = 16'h0000; // [RULE21]
            r.dn = 1'b0;
        end
        else if (!ctr)
        begin
            r.dn = 1'b0; // [RULE6]
            if (cnt >= per - 16'h0001)
            begin
                r.cnt = 16'h0000; // [RULE4] [RULE7] [RULE8]
                r.rst = 1'b1;
                r.load = 1'b1;
            end
            else
            begin
                r.cnt = cnt + 16'h0001;
            end
        end
        else
        begin
            if (!dn)
            begin
                if (cnt >= per)
                begin
                    r.dn = 1'b1; // [RULE10]
                    r.cnt = cnt - 16'h0001;
                end
                else
                begin
                    r.cnt = cnt + 16'h0001;
                end
            end
            else if (cnt != 16'h0000)
            begin
                r.cnt = cnt - 16'h0001;
            end
            if (r.cnt == 16'h0000)
            begin
                // Zero forces up; a downward arrival ends the period
                if (r.dn || dn)
                begin
                    r.rst = 1'b1; // [RULE9] [RULE11] [RULE12] [RULE4]
                    r.load = 1'b1;
                end
                r.dn = 1'b0; // [RULE9]
            end
        end
        r.tog = !r.rst && (r.cnt == dty); // [RULE6] [RULE10] [RULE26]
        return r;
    endfunction : pwc_step

    // Decode an address against a six-word channel region
    function automatic pwc_slot_s pwc_slot(
        input logic [7:0] a,
        input logic [7:0] base
    );
        pwc_slot_s s;
        logic [7:0] o;
        o = a - base;
        s.hit = (a >= base) && (o < `PWC_REGION_SPAN) && (o[1:0] == 2'b00);
        s.idx = o[4:2];
        return s;
    endfunction : pwc_slot

    // Software registers
    logic [5:0] en_q;
    logic [5:0] pol_q;
    logic [5:0] cae_q;
    logic [2:0] pair_q;
    logic [7:0] per_buf_q [6];
    logic [7:0] dty_buf_q [6];

    // Channel state
    logic [7:0] cnt_q [6];
    logic [7:0] cnt_d [6];
    logic [7:0] per_act_q [6];
    logic [7:0] per_act_d [6];
    logic [7:0] dty_act_q [6];
    logic [7:0] dty_act_d [6];
    logic [5:0] dn_q;
    logic [5:0] dn_d;
    logic [5:0] ff_q;
    logic [5:0] ff_d;
    logic [5:0] out_d;
    logic [5:0] oe_d;

    // Bus handshake
    logic ack_q;
    logic wr_go;
    logic [31:0] rdata_d;
    logic [5:0] cnt_wr;
    pwc_slot_s cnt_slot;
    pwc_slot_s per_slot;
    pwc_slot_s dty_slot;

    // One wait state: the request is taken on the edge where ack_q is high
    assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
    assign wr_go = avs_write && ack_q;
    assign cnt_slot = pwc_slot(avs_address, `PWC_BASE_COUNT);
    assign per_slot = pwc_slot(avs_address, `PWC_BASE_PERIOD);
    assign dty_slot = pwc_slot(avs_address, `PWC_BASE_DUTY);

    // Counter write strobes, any byte lane counts as a write
    always_comb
    begin
        cnt_wr = 6'h00;
        if (wr_go && cnt_slot.hit && (avs_byteenable != 4'h0))
        begin
            cnt_wr[cnt_slot.idx] = 1'b1; // [RULE1] [RULE17]
        end
    end

    // Handshake phase flop
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= (avs_read || avs_write) && !ack_q;
        end
    end

    // Read data mux, registered one cycle before the answer
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (cnt_slot.hit)
        begin
            if (pair_q[cnt_slot.idx[2:1]])
            begin
                // Joined pair reads coherently as one 16-bit value
                rdata_d[15:8] = cnt_q[{cnt_slot.idx[2:1], 1'b0}]; // [RULE17]
                rdata_d[7:0] = cnt_q[{cnt_slot.idx[2:1], 1'b1}];
            end
            else
            begin
                rdata_d[7:0] = cnt_q[cnt_slot.idx];
            end
        end
        else if (per_slot.hit)
        begin
            rdata_d[7:0] = per_buf_q[per_slot.idx];
        end
        else if (dty_slot.hit)
        begin
            rdata_d[7:0] = dty_buf_q[dty_slot.idx];
        end
        else
        begin
            case (avs_address)
                `PWC_OFS_ENABLE: rdata_d[5:0] = en_q;
                `PWC_OFS_POLARITY: rdata_d[5:0] = pol_q;
                `PWC_OFS_ALIGN: rdata_d[5:0] = cae_q;
                `PWC_OFS_PAIRING: rdata_d[2:0] = pair_q;
                `PWC_OFS_STATE: rdata_d[13:0] = {pwm_out, 2'b00, dn_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (avs_read && !ack_q)
        begin
            avs_readdata <= rdata_d;
        end
    end

    // Control registers written over the bus
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            en_q <= `PWC_RST_BITS6; // [RULE25]
            pol_q <= `PWC_RST_BITS6;
            cae_q <= `PWC_RST_BITS6;
            pair_q <= `PWC_RST_BITS3;
        end
        else if (wr_go && avs_byteenable[0])
        begin
            case (avs_address)
                `PWC_OFS_ENABLE: en_q <= avs_writedata[5:0];
                `PWC_OFS_POLARITY: pol_q <= avs_writedata[5:0];
                `PWC_OFS_ALIGN: cae_q <= avs_writedata[5:0]; // [RULE5]
                `PWC_OFS_PAIRING: pair_q <= avs_writedata[2:0]; // [RULE14]
                default: pair_q <= pair_q;
            endcase
        end
    end

    // Period and duty buffers
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            for (int c = 0; c < `PWC_NCH; c++)
            begin
                per_buf_q[c] <= `PWC_RST_BYTE;
                dty_buf_q[c] <= `PWC_RST_BYTE;
            end
        end
        else if (wr_go && avs_byteenable[0])
        begin
            if (per_slot.hit)
            begin
                per_buf_q[per_slot.idx] <= avs_writedata[7:0];
            end
            if (dty_slot.hit)
            begin
                dty_buf_q[dty_slot.idx] <= avs_writedata[7:0];
            end
        end
    end

    // Next state of every channel; a joined pair is handled by its odd channel
    always_comb
    begin
        logic j;
        logic hi_on;
        logic run;
        logic [15:0] cnt16;
        logic [15:0] per16;
        logic [15:0] dty16;
        logic [15:0] pbuf16;
        logic [15:0] dbuf16;
        logic [15:0] nper;
        logic [15:0] ndty;
        pwc_step_s st;
        j = 1'b0;
        hi_on = 1'b0;
        run = 1'b0;
        cnt16 = 16'h0000;
        per16 = 16'h0000;
        dty16 = 16'h0000;
        pbuf16 = 16'h0000;
        dbuf16 = 16'h0000;
        nper = 16'h0000;
        ndty = 16'h0000;
        st = '0;
        cnt_d = cnt_q;
        per_act_d = per_act_q;
        dty_act_d = dty_act_q;
        dn_d = dn_q;
        ff_d = ff_q;
        out_d = 6'h00;
        oe_d = 6'h00;
        for (int c = 0; c < `PWC_NCH; c++)
        begin
            j = pair_q[c / 2];
            if ((c % 2 == 1) || !j)
            begin
                hi_on = j && (c % 2 == 1);
                // Build 16-bit views; even byte is high when joined
                cnt16 = {hi_on ? cnt_q[c ^ 1] : 8'h00, cnt_q[c]}; // [RULE14] [RULE26]
                per16 = {hi_on ? per_act_q[c ^ 1] : 8'h00, per_act_q[c]};
                dty16 = {hi_on ? dty_act_q[c ^ 1] : 8'h00, dty_act_q[c]};
                pbuf16 = {hi_on ? per_buf_q[c ^ 1] : 8'h00, per_buf_q[c]};
                dbuf16 = {hi_on ? dty_buf_q[c ^ 1] : 8'h00, dty_buf_q[c]};
                run = en_q[c] && chan_tick[c]; // [RULE3] [RULE15] [RULE16]
                st = pwc_step(cnt16, dn_q[c], per16, dty16, cae_q[c]); // [RULE18]
                nper = per16;
                ndty = dty16;
                if (cnt_wr[c] || (hi_on && cnt_wr[c ^ 1]))
                begin
                    cnt16 = 16'h0000; // [RULE1] [RULE2] [RULE17]
                    dn_d[c] = 1'b0;
                    ff_d[c] = 1'b0;
                    nper = pbuf16;
                    ndty = dbuf16;
                end
                else if (run)
                begin
                    cnt16 = st.cnt;
                    dn_d[c] = st.dn;
                    if (st.rst)
                    begin
                        ff_d[c] = 1'b0; // [RULE7] [RULE11]
                    end
                    else if (st.tog)
                    begin
                        ff_d[c] = !ff_q[c]; // [RULE6] [RULE10]
                    end
                    if (st.load)
                    begin
                        nper = pbuf16; // [RULE24]
                        ndty = dbuf16;
                    end
                end
                if (!en_q[c])
                begin
                    // Disabled: buffer writes reach the active values at once
                    nper = pbuf16; // [RULE24]
                    ndty = dbuf16;
                end
                cnt_d[c] = cnt16[7:0];
                per_act_d[c] = nper[7:0];
                dty_act_d[c] = ndty[7:0];
                if (hi_on)
                begin
                    cnt_d[c ^ 1] = cnt16[15:8];
                    per_act_d[c ^ 1] = nper[15:8];
                    dty_act_d[c ^ 1] = ndty[15:8];
                end
                // Output level with boundary cases taking priority
                if (per16 == 16'h0000)
                begin
                    out_d[c] = pol_q[c]; // [RULE21]
                end
                else if (dty16 == 16'h0000)
                begin
                    out_d[c] = !pol_q[c]; // [RULE20]
                end
                else if (dty16 >= per16)
                begin
                    out_d[c] = pol_q[c]; // [RULE20]
                end
                else
                begin
                    out_d[c] = pol_q[c] ^ ff_q[c]; // [RULE13] [RULE15]
                end
                oe_d[c] = en_q[c];
                if (!en_q[c])
                begin
                    out_d[c] = 1'b0;
                end
            end
        end
    end

    // Channel state registers
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            for (int c = 0; c < `PWC_NCH; c++)
            begin
                cnt_q[c] <= `PWC_RST_BYTE;
                per_act_q[c] <= `PWC_RST_BYTE;
                dty_act_q[c] <= `PWC_RST_BYTE;
            end
            dn_q <= `PWC_RST_BITS6; // [RULE25]
            ff_q <= `PWC_RST_BITS6;
        end
        else
        begin
            cnt_q <= cnt_d;
            per_act_q <= per_act_d;
            dty_act_q <= dty_act_d;
            dn_q <= dn_d;
            ff_q <= ff_d;
        end
    end

    // Registered pin outputs; even channel of a joined pair stays off
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            pwm_out <= `PWC_RST_BITS6;
            pwm_out_en <= `PWC_RST_BITS6;
        end
        else
        begin
            pwm_out <= out_d;
            pwm_out_en <= oe_d; // [RULE16]
        end
    end

endmodule : pwc_core
